// >>> core/serial_port_pkg.sv
// Shared constants for the byte-wide serial port register block.
package serial_port_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0]  IDX_CONTROL = 8'h10;
  localparam logic [7:0]  IDX_STATUS  = 8'h11;
  localparam logic [7:0]  IDX_DATA    = 8'h12;
  localparam logic [31:0] ADDR_CONTROL = {22'h000000, IDX_CONTROL, 2'h0};
  localparam logic [31:0] ADDR_STATUS  = {22'h000000, IDX_STATUS, 2'h0};
  localparam logic [31:0] ADDR_DATA    = {22'h000000, IDX_DATA, 2'h0};

  // Control register field positions.
  localparam int CTL_RX_FULL_IRQ_EN = 7;
  localparam int CTL_MASTER_SELECT  = 5;
  localparam int CTL_CLOCK_POLARITY = 4;
  localparam int CTL_CLOCK_PHASE    = 3;
  localparam int CTL_WIRED_OR_MODE  = 2;
  localparam int CTL_PORT_ENABLE    = 1;
  localparam int CTL_TX_EMPTY_IRQ_EN = 0;

  // Status and control register field positions.
  localparam int STS_RX_FULL_FLAG    = 7;
  localparam int STS_ERROR_IRQ_EN    = 6;
  localparam int STS_OVERRUN_FLAG    = 5;
  localparam int STS_MODE_FAULT_FLAG = 4;
  localparam int STS_TX_EMPTY_FLAG   = 3;
  localparam int STS_MODE_FAULT_DETECT_EN = 2;
  localparam int STS_RATE_SELECT_HI  = 1;
  localparam int STS_RATE_SELECT_LO  = 0;

  // Values after reset.
  localparam logic [7:0] CONTROL_RESET = 8'h28;
  localparam logic [7:0] STATUS_RESET  = 8'h08;

  // Rate divisors for rate select codes 00, 01, 10 and 11.
  localparam logic [7:0] RATE_DIVISOR_0 = 8'h02;
  localparam logic [7:0] RATE_DIVISOR_1 = 8'h08;
  localparam logic [7:0] RATE_DIVISOR_2 = 8'h20;
  localparam logic [7:0] RATE_DIVISOR_3 = 8'h80;

  // Sixteen serial clock edges in one byte; this is the index of the last one.
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // AHB-Lite transfer type bit that marks an active transfer, and the OKAY answer.
  localparam int          HTRANS_ACTIVE_BIT = 1;
  localparam logic        HRESP_OKAY = 1'b0;

endpackage

// >>> core/serial_port_core.sv
// Byte-wide serial port, master or slave, with its registers on an AHB-Lite slave.
// How it works
// (R1) Receive-full and transmit-empty raise the interrupt only under their own enables.
// (R2) Master-select 1 gives master, 0 slave; reset leaves it at master.
// (R3) Polarity sets idle clock level, reset 0; phase sets sampling, reset 1.
// (R4) Both ends share polarity and phase; phase 0 needs select high between bytes.
// (R5) Slave phase 0: falling select starts transfer and drives the top bit out.
// (R6) Once a slave transfer runs, new transmit data waits in the buffer.
// (R7) Slave phase 1: first clock edge starts transfer; select may stay low.
// (R8) Slave with select high floats its output and ignores clocks, state kept.
// (R9) Wired-OR mode makes clock and both data pins open drain, else push-pull.
// (R10) Port runs only while enabled; clearing enable resets the transfer logic.
// (R11) Receive-full sets on each received byte; any data read or reset clears it.
// (R12) Error interrupt enable gates overrun and mode-fault interrupts; reset clears it.
// (R13) Byte arriving while receive full sets overrun, keeps old; status then data read clears.
// (R14) Detection on: slave select rising mid-transfer, or master select low, sets mode fault.
// (R15) Status read with mode fault set, then control write, clears it; detect-off does not.
// (R16) Detection off: master ignores select and releases it; slave still uses select.
// (R17) Transmit-empty sets on each buffer load, within two cycles when idle; reset sets it.
// (R18) Software writes data only while transmit-empty is high.
// (R19) Master rate codes pick divisor 2, 8, 32, 128; clock is base over twice that.
// (R20) Data writes go to transmit buffer, reads come from separate receive buffer.
// (R21) One interrupt output, high while any enabled flag is set.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module serial_port_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        select_n_in,
  output logic             select_released,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic        rx_full_irq_en_r;
  logic        master_select_r;
  logic        clock_polarity_r;
  logic        clock_phase_r;
  logic        wired_or_mode_r;
  logic        port_enable_r;
  logic        tx_empty_irq_en_r;
  logic        error_irq_en_r;
  logic        mode_fault_detect_en_r;
  logic [1:0]  rate_select_r;
  logic        rx_full_flag_r;
  logic        overrun_flag_r;
  logic        mode_fault_flag_r;
  logic        overrun_armed_r;
  logic        mode_fault_armed_r;
  logic [7:0]  tx_buf_r;
  logic        tx_full_r;
  logic [7:0]  rx_buf_r;
  logic [7:0]  shift_r;
  logic        rx_bit_r;
  logic        active_r;
  logic [3:0]  edge_cnt_r;
  logic [7:0]  div_cnt_r;
  logic        sck_toggle_r;
  logic        sck_prev_r;
  logic        select_prev_r;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic        take;
  logic        rd_take;
  logic        rd_data;
  logic        rd_status;
  logic        wr_control;
  logic        wr_status;
  logic        wr_data;
  logic        master_mode;
  logic        slave_mode;
  logic [7:0]  rate_divisor;
  logic        master_tick;
  logic        slave_edge;
  logic        slave_start_ph0;
  logic        slave_start_ph1;
  logic        edge_ev;
  logic        sample_edge;
  logic        shift_edge;
  logic        byte_done;
  logic        in_bit;
  logic [7:0]  rx_byte;
  logic        load;
  logic        master_fault;
  logic        slave_fault;
  logic        sck_level;
  logic        miso_drive;
  logic [7:0]  control_val;
  logic [7:0]  status_val;
  // Maps a rate select code to its divisor.
  function automatic logic [7:0] divisor_of(input logic [1:0] code);
    logic [7:0] d;
    d = serial_port_pkg::RATE_DIVISOR_0;
    unique case (code)
      2'h0: d = serial_port_pkg::RATE_DIVISOR_0;
      2'h1: d = serial_port_pkg::RATE_DIVISOR_1;
      2'h2: d = serial_port_pkg::RATE_DIVISOR_2;
      2'h3: d = serial_port_pkg::RATE_DIVISOR_3;
    endcase
    return d;
  endfunction
  // Drives a pin push-pull, or only low when wired-OR mode is on.
  function automatic logic [1:0] pin_drive(input logic drive, input logic val,
                                           input logic open_drain);
    logic [1:0] r;
    r = {drive, val};
    if (open_drain) begin
      r = {drive & ~val, 1'b0};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. Reads are answered from the address phase so no wait state is needed.
  assign take      = hsel & hready & htrans[serial_port_pkg::HTRANS_ACTIVE_BIT];
  assign rd_take   = take & ~hwrite;
  assign rd_data   = rd_take & (haddr == serial_port_pkg::ADDR_DATA);
  assign rd_status = rd_take & (haddr == serial_port_pkg::ADDR_STATUS);
  assign wr_control = wr_pend_r & (wr_addr_r == serial_port_pkg::ADDR_CONTROL);
  assign wr_status  = wr_pend_r & (wr_addr_r == serial_port_pkg::ADDR_STATUS);
  assign wr_data    = wr_pend_r & (wr_addr_r == serial_port_pkg::ADDR_DATA);
  assign hreadyout = 1'b1;
  assign hresp     = serial_port_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_r;
  // Captures the address phase of a write for use in its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
    end else begin
      wr_pend_r <= take & hwrite;
      wr_addr_r <= haddr;
    end
  end
  // Read values; reserved and unmapped bits read as zero.
  always_comb begin
    control_val = 8'h00;
    control_val[serial_port_pkg::CTL_RX_FULL_IRQ_EN] = rx_full_irq_en_r;
    control_val[serial_port_pkg::CTL_MASTER_SELECT]  = master_select_r;
    control_val[serial_port_pkg::CTL_CLOCK_POLARITY] = clock_polarity_r;
    control_val[serial_port_pkg::CTL_CLOCK_PHASE]    = clock_phase_r;
    control_val[serial_port_pkg::CTL_WIRED_OR_MODE]  = wired_or_mode_r;
    control_val[serial_port_pkg::CTL_PORT_ENABLE]    = port_enable_r;
    control_val[serial_port_pkg::CTL_TX_EMPTY_IRQ_EN] = tx_empty_irq_en_r;
    status_val = 8'h00;
    status_val[serial_port_pkg::STS_RX_FULL_FLAG]    = rx_full_flag_r;
    status_val[serial_port_pkg::STS_ERROR_IRQ_EN]    = error_irq_en_r;
    status_val[serial_port_pkg::STS_OVERRUN_FLAG]    = overrun_flag_r;
    status_val[serial_port_pkg::STS_MODE_FAULT_FLAG] = mode_fault_flag_r;
    status_val[serial_port_pkg::STS_TX_EMPTY_FLAG]   = ~tx_full_r;
    status_val[serial_port_pkg::STS_MODE_FAULT_DETECT_EN] = mode_fault_detect_en_r;
    status_val[serial_port_pkg::STS_RATE_SELECT_HI]  = rate_select_r[1];
    status_val[serial_port_pkg::STS_RATE_SELECT_LO]  = rate_select_r[0];
  end
  // Read data register, loaded at the address phase edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_take) begin
      if (haddr == serial_port_pkg::ADDR_CONTROL) begin
        hrdata_r <= {24'h000000, control_val};
      end else if (haddr == serial_port_pkg::ADDR_STATUS) begin
        hrdata_r <= {24'h000000, status_val};
      end else if (haddr == serial_port_pkg::ADDR_DATA) begin
        hrdata_r <= {24'h000000, rx_buf_r}; // (R20)
      end else begin
        hrdata_r <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits. A master mode fault drops the enable so two masters stop fighting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_irq_en_r  <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_RX_FULL_IRQ_EN];
      master_select_r   <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_MASTER_SELECT];
      clock_polarity_r  <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_CLOCK_POLARITY];
      clock_phase_r     <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_CLOCK_PHASE];
      wired_or_mode_r   <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_WIRED_OR_MODE];
      port_enable_r     <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_PORT_ENABLE];
      tx_empty_irq_en_r <= serial_port_pkg::CONTROL_RESET[serial_port_pkg::CTL_TX_EMPTY_IRQ_EN];
    end else begin
      if (wr_control) begin
        rx_full_irq_en_r  <= hwdata[serial_port_pkg::CTL_RX_FULL_IRQ_EN]; // (R1)
        master_select_r   <= hwdata[serial_port_pkg::CTL_MASTER_SELECT]; // (R2)
        clock_polarity_r  <= hwdata[serial_port_pkg::CTL_CLOCK_POLARITY]; // (R3)
        clock_phase_r     <= hwdata[serial_port_pkg::CTL_CLOCK_PHASE]; // (R3)
        wired_or_mode_r   <= hwdata[serial_port_pkg::CTL_WIRED_OR_MODE]; // (R9)
        port_enable_r     <= hwdata[serial_port_pkg::CTL_PORT_ENABLE]; // (R10)
        tx_empty_irq_en_r <= hwdata[serial_port_pkg::CTL_TX_EMPTY_IRQ_EN]; // (R1)
      end
      if (master_fault) begin
        port_enable_r <= 1'b0;
      end
    end
  end
  // Writable bits of the status and control register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_irq_en_r <= serial_port_pkg::STATUS_RESET[serial_port_pkg::STS_ERROR_IRQ_EN];
      mode_fault_detect_en_r <=
        serial_port_pkg::STATUS_RESET[serial_port_pkg::STS_MODE_FAULT_DETECT_EN];
      rate_select_r <= serial_port_pkg::STATUS_RESET[serial_port_pkg::STS_RATE_SELECT_HI:
                                                      serial_port_pkg::STS_RATE_SELECT_LO];
    end else if (wr_status) begin
      error_irq_en_r <= hwdata[serial_port_pkg::STS_ERROR_IRQ_EN]; // (R12)
      mode_fault_detect_en_r <= hwdata[serial_port_pkg::STS_MODE_FAULT_DETECT_EN];
      rate_select_r <= hwdata[serial_port_pkg::STS_RATE_SELECT_HI:
                              serial_port_pkg::STS_RATE_SELECT_LO]; // (R19)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer engine decode.
  assign master_mode  = port_enable_r & master_select_r; // (R2) (R10)
  assign slave_mode   = port_enable_r & ~master_select_r;
  assign rate_divisor = divisor_of(rate_select_r); // (R19)
  // Each tick is half a serial clock period, so the period is twice the divisor.
  assign master_tick  = master_mode & active_r & (div_cnt_r == rate_divisor - 8'h01); // (R19)
  // A deselected slave sees no clock edges at all.
  assign slave_edge   = slave_mode & ~select_n_in & (sck_in != sck_prev_r); // (R8)
  assign slave_start_ph0 = slave_mode & ~active_r & ~clock_phase_r
                           & select_prev_r & ~select_n_in; // (R5)
  assign slave_start_ph1 = ~active_r & clock_phase_r & slave_edge; // (R7)
  assign edge_ev     = active_r ? (master_mode ? master_tick : slave_edge) : slave_start_ph1;
  assign sample_edge = edge_ev & (edge_cnt_r[0] == clock_phase_r);
  assign shift_edge  = edge_ev & ~sample_edge & (edge_cnt_r != 4'h0);
  assign byte_done   = edge_ev & (edge_cnt_r == serial_port_pkg::LAST_EDGE);
  assign in_bit      = master_select_r ? miso_in : mosi_in;
  assign rx_byte     = {shift_r[6:0], clock_phase_r ? in_bit : rx_bit_r};
  // An active slave holds the buffer until its byte is over.
  assign load        = port_enable_r & tx_full_r & ~active_r; // (R6) (R17)
  assign master_fault = master_mode & mode_fault_detect_en_r & ~select_n_in; // (R14) (R16)
  assign slave_fault  = slave_mode & mode_fault_detect_en_r & active_r
                        & select_n_in & ~select_prev_r; // (R14)
  // Transfer state, edge counter and clock divider; disabling is a partial reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r     <= 1'b0;
      edge_cnt_r   <= 4'h0;
      div_cnt_r    <= 8'h00;
      sck_toggle_r <= 1'b0;
    end else if (!port_enable_r) begin
      active_r     <= 1'b0; // (R10)
      edge_cnt_r   <= 4'h0;
      div_cnt_r    <= 8'h00;
      sck_toggle_r <= 1'b0;
    end else begin
      if (master_mode & load) begin
        active_r <= 1'b1;
      end else if (slave_start_ph0 | slave_start_ph1) begin
        active_r <= ~byte_done; // (R5) (R7)
      end else if (byte_done) begin
        active_r <= 1'b0;
      end
      if (edge_ev) begin
        edge_cnt_r <= edge_cnt_r + 4'h1;
      end
      if (master_tick | ~active_r) begin
        div_cnt_r <= 8'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
      if (master_tick) begin
        sck_toggle_r <= ~sck_toggle_r;
      end
    end
  end
  // Edge detectors on the slave clock and select inputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_prev_r    <= 1'b0;
      select_prev_r <= 1'b1;
    end else begin
      sck_prev_r    <= sck_in;
      select_prev_r <= select_n_in;
    end
  end
  // Shift register: sample on one edge, shift on the other.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r  <= 8'h00;
      rx_bit_r <= 1'b0;
    end else begin
      if (load) begin
        shift_r <= tx_buf_r; // (R17)
      end else if (shift_edge) begin
        shift_r <= {shift_r[6:0], rx_bit_r};
      end
      if (sample_edge) begin
        rx_bit_r <= in_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffers. Neither is reset, as software may still read the last byte.
  always_ff @(posedge hclk) begin
    if (wr_data) begin
      tx_buf_r <= hwdata[7:0]; // (R20) (R18)
    end
    if (byte_done & ~rx_full_flag_r) begin
      rx_buf_r <= rx_byte; // (R13)
    end
  end
  // Transmit full, seen by software as transmit-empty; a write needs the flag high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_full_r <= ~serial_port_pkg::STATUS_RESET[serial_port_pkg::STS_TX_EMPTY_FLAG];
    end else if (!port_enable_r) begin
      tx_full_r <= 1'b0;
    end else if (wr_data) begin
      tx_full_r <= 1'b1;
    end else if (load) begin
      tx_full_r <= 1'b0; // (R17)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags. Hardware setting always wins over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_flag_r <= 1'b0;
    end else if (byte_done) begin
      rx_full_flag_r <= 1'b1; // (R11)
    end else if (rd_data) begin
      rx_full_flag_r <= 1'b0; // (R11)
    end
  end
  // Overrun: armed by a status read that sees it, cleared by a later data read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_flag_r  <= 1'b0;
      overrun_armed_r <= 1'b0;
    end else if (byte_done & rx_full_flag_r) begin
      overrun_flag_r  <= 1'b1; // (R13)
      overrun_armed_r <= 1'b0;
    end else if (rd_data & overrun_armed_r) begin
      overrun_flag_r  <= 1'b0; // (R13)
      overrun_armed_r <= 1'b0;
    end else if (rd_status & overrun_flag_r) begin
      overrun_armed_r <= 1'b1;
    end
  end
  // Mode fault: armed by a status read, cleared by a later control write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_fault_flag_r  <= 1'b0;
      mode_fault_armed_r <= 1'b0;
    end else if (master_fault | slave_fault) begin
      mode_fault_flag_r  <= 1'b1; // (R14)
      mode_fault_armed_r <= 1'b0;
    end else if (wr_control & mode_fault_armed_r) begin
      mode_fault_flag_r  <= 1'b0; // (R15)
      mode_fault_armed_r <= 1'b0;
    end else if (rd_status & mode_fault_flag_r) begin
      mode_fault_armed_r <= 1'b1; // (R15)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt.
  assign sck_level  = clock_polarity_r ^ sck_toggle_r; // (R3)
  assign miso_drive = slave_mode & ~select_n_in; // (R8)
  assign {sck_oe, sck_out}   = pin_drive(master_mode, sck_level, wired_or_mode_r); // (R9)
  assign {mosi_oe, mosi_out} = pin_drive(master_mode, shift_r[7], wired_or_mode_r); // (R9)
  assign {miso_oe, miso_out} = pin_drive(miso_drive, shift_r[7], wired_or_mode_r); // (R9) (R5)
  // Select is free for general use when disabled or a master without detection.
  assign select_released = ~port_enable_r | (master_select_r & ~mode_fault_detect_en_r); // (R16)
  assign irq = (rx_full_flag_r & rx_full_irq_en_r) | (~tx_full_r & tx_empty_irq_en_r) // (R1)
             | ((overrun_flag_r | mode_fault_flag_r) & error_irq_en_r); // (R12) (R21)
endmodule

`default_nettype wire

// >>> test/serial_port_properties.sv
// Port-level assertions for the serial port register block.
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        select_n_in,
  input wire logic        irq
);
  logic rd_take;
  logic hit;

  // A read is taken only with select, ready and an active transfer.
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign hit = haddr inside {serial_port_pkg::ADDR_CONTROL, serial_port_pkg::ADDR_STATUS,
                             serial_port_pkg::ADDR_DATA};

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_bus_no_wait: assert property (hreadyout && hresp == serial_port_pkg::HRESP_OKAY)
    else $error("bus slave stalled or answered an error");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_unmapped_zero: assert property (rd_take && !hit |=> hrdata == 32'h0)
    else $error("unmapped read returned data");
  chk_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_sck_half_min: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
    else $error("serial clock half period below two cycles");
  chk_miso_floats: assert property (select_n_in [*3] |-> !miso_oe)
    else $error("slave output driven while deselected");
  chk_one_data_driver: assert property (!(mosi_oe && miso_oe))
    else $error("both data outputs driven at once");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && !sck_oe && !mosi_oe)
    else $error("port active or interrupt high after reset");
endmodule

bind serial_port_core serial_port_properties i_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .sck_out, .sck_oe, .mosi_oe, .miso_oe,
  .select_n_in, .irq);
`default_nettype wire

// >>> test/serial_peer_model.sv
// Far-end serial slave for polarity 0, phase 1 frames.
`timescale 1ns/100ps
`default_nettype none
module serial_peer_model (
  input  wire logic       hclk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic       sck_q = 1'b0;
  logic [2:0] bit_idx = 3'h0;

  initial miso = 1'b1;

  // Leading edge puts the next bit out, trailing edge captures one, MSB first.
  always @(posedge hclk) begin
    sck_q <= sck;
    if (sck && !sck_q) begin
      miso <= tx_byte[~bit_idx];
    end
    if (!sck && sck_q) begin
      rx_byte <= {rx_byte[6:0], mosi};
      bit_idx <= bit_idx + 3'h1;
      if (bit_idx == 3'h7) begin
        miso <= ~miso; // Stale bit is inverted so it is never mistaken for data.
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the serial port register block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] CTL = serial_port_pkg::ADDR_CONTROL;
  localparam logic [31:0] STS = serial_port_pkg::ADDR_STATUS;
  localparam logic [31:0] DAT = serial_port_pkg::ADDR_DATA;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        sel_n = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [7:0]  peer_tx = 8'h00;
  logic [7:0]  peer_rx, byte_a;
  logic        hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe;
  logic        miso_out, miso_oe, sel_free, irq, peer_miso;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          span;
  // Clock idles low through a pull-down, MOSI is pulled up and an undriven MISO is driven by the peer.
  wire         sck_pin = sck_oe ? sck_out : 1'b0;
  wire         mosi_pin = mosi_oe ? mosi_out : 1'b1;
  wire         miso_pin = miso_oe ? miso_out : peer_miso;

  always #50 hclk = ~hclk;

  serial_port_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
    .select_n_in(sel_n), .select_released(sel_free), .irq(irq));
  serial_peer_model i_peer (.hclk(hclk), .sck(sck_pin), .mosi(mosi_pin), .tx_byte(peer_tx),
    .miso(peer_miso), .rx_byte(peer_rx));

  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [7:0] data);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= addr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, data};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [31:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, 8'h00);
    check(what, rd, exp);
  endtask

  // The interrupt follows register state, so look half a cycle after the write lands.
  task automatic irq_chk(input logic exp);
    @(negedge hclk);
    check("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge hclk);
  endtask

  // Polls status until a masked bit rises; the bound only guards against a hang.
  task automatic wait_flag(input logic [7:0] mask);
    bus(1'b0, STS, 8'h00);
    for (int n = 0; n < 3000 && (rd[7:0] & mask) == 8'h00; n++) bus(1'b0, STS, 8'h00);
  endtask

  // Cycles until the serial clock next changes level.
  task automatic sck_turn(output int cycles);
    logic s;
    s = sck_out;
    cycles = 0;
    while (sck_out === s) begin
      @(posedge hclk);
      cycles++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under ten thousand cycles; this cuts a hang short.
  initial begin
    repeat (40000) @(posedge hclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(27610));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(CTL, 32'h28, "ctl reset");
    rchk(STS, 32'h08, "sts reset");
    rchk(32'h4C, 32'h0, "unmapped");
    bus(1'b1, STS, 8'hFF);
    rchk(STS, 32'h4F, "flags read only");
    // One frame at every rate code, random bytes both ways except a fixed 81 sent at code 3.
    for (int code = 0; code < 4; code++) begin
      peer_tx <= 8'($urandom);
      byte_a = (code == 3) ? 8'h81 : 8'($urandom);
      bus(1'b1, STS, 8'(code));
      bus(1'b1, CTL, 8'h2A);
      bus(1'b1, DAT, byte_a);
      sck_turn(span);
      sck_turn(span);
      check("half period", 32'(span), 32'(2 << (2 * code)));
      wait_flag(8'h80);
      check("rx status", rd, 32'(8'h88 + code));
      check("peer rx", {24'h0, peer_rx}, {24'h0, byte_a});
      rchk(DAT, {24'h0, peer_tx}, "rx data");
      rchk(STS, 32'(8'h08 + code), "rx cleared");
    end
    // Second byte arrives unread: old byte kept, overrun raised.
    bus(1'b1, STS, 8'h00);
    peer_tx <= 8'hA5;
    bus(1'b1, DAT, 8'h3C);
    wait_flag(8'h80);
    peer_tx <= 8'h5A;
    bus(1'b1, DAT, 8'hC3);
    wait_flag(8'h20);
    check("overrun", rd, 32'hA8);
    irq_chk(1'b0);
    bus(1'b1, STS, 8'h40);
    irq_chk(1'b1);
    bus(1'b1, STS, 8'h00);
    bus(1'b1, CTL, 8'hAA);
    irq_chk(1'b1);
    bus(1'b1, CTL, 8'h2B);
    irq_chk(1'b1);
    bus(1'b1, CTL, 8'h2A);
    irq_chk(1'b0);
    rchk(STS, 32'hA8, "ovr arm");
    rchk(DAT, 32'hA5, "old byte");
    rchk(STS, 32'h08, "ovr clear");
    // Master sees select low with detection on.
    bus(1'b1, STS, 8'h04);
    sel_n <= 1'b0;
    wait_flag(8'h10);
    check("fault", rd, 32'h1C);
    rchk(CTL, 32'h28, "fault disable");
    sel_n <= 1'b1;
    bus(1'b1, STS, 8'h00);
    rchk(STS, 32'h18, "fault kept");
    bus(1'b1, CTL, 8'h2A);
    rchk(STS, 32'h08, "fault clear");
    sel_n <= 1'b0;
    repeat (2) rchk(STS, 32'h08, "sel ignored");
    check("sel free", {31'h0, sel_free}, 32'h1);
    bus(1'b1, CTL, 8'h3E);
    irq_chk(1'b0);
    check("wired-or idle", {31'h0, sck_oe}, 32'h0);
    bus(1'b1, CTL, 8'h0A);
    irq_chk(1'b0);
    check("slave out", {31'h0, miso_oe}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
